/* File: rtl/clock_select_pkg.sv */
package clock_select_pkg;

    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_FLAGS      = 3'h3;
    localparam logic [2:0] IDX_IRQ_ENABLE = 3'h4;
    localparam logic [2:0] IDX_CLK_SELECT = 3'h5;

    // enable register fields
    localparam int BIT_PERIODIC_IRQ_EN  = 7;
    localparam int BIT_LOCK_IRQ_EN      = 4;
    localparam int BIT_SELFCLK_IRQ_EN   = 1;

    // clock select register fields
    localparam int BIT_PLL_AS_SYSTEM_CLOCK    = 7;
    localparam int BIT_OSC_RUN_IN_STOP  = 6;
    localparam int BIT_OSC_CONFIG       = 5;
    localparam int BIT_PLL_HALT_WAIT    = 3;
    localparam int BIT_PERIODIC_HALT    = 1;
    localparam int BIT_WATCHDOG_HALT    = 0;

    // flag register fields
    localparam int BIT_PERIODIC_FLAG    = 7;
    localparam int BIT_LOCK_FLAG        = 4;
    localparam int BIT_LOCK_STATUS      = 3;
    localparam int BIT_SELFCLK_FLAG     = 1;
    localparam int BIT_SELFCLK_STATUS   = 0;

    // values after reset, and the read value of unmapped indices
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic       CTRL_BIT_RESET   = 1'b0;
    localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

    // system clock to bus clock ratio for either source
    localparam int BUS_CLOCK_DIVIDE = 2;

endpackage

/* File: rtl/reg_access_if.sv */
`timescale 1ns/1ps
// one register access, granted by the bus port for a single cycle
interface reg_access_if;
    logic       access;
    logic       write;
    logic [2:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus (
        output access,
        output write,
        output index,
        output wdata,
        input  rdata
    );
    modport regs (
        input  access,
        input  write,
        input  index,
        input  wdata,
        output rdata
    );
endinterface

/* File: rtl/change_flag.sv */
`timescale 1ns/1ps
// sticky event flag; a set in the clearing cycle wins
module change_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // event and software clear
    input  wire logic set_evt,
    input  wire logic clear_req,
    // flag
    output logic      flag
);
    // set has priority over clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clear_req) begin
            flag <= 1'b0;
        end
    end
endmodule

/* File: rtl/avalon_reg_port.sv */
`timescale 1ns/1ps
// avalon-mm slave: one wait cycle, then a single-cycle grant
module avalon_reg_port (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // avalon-mm slave
    input  wire logic [4:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    // register side
    reg_access_if.bus       acc
);
    logic request;

    assign request    = avs_read | avs_write;
    // grant coincides with the edge where waitrequest is seen low
    assign acc.access = request & ~avs_waitrequest;
    assign acc.write  = avs_write;
    assign acc.index  = avs_address[4:2];
    assign acc.wdata  = avs_writedata;

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if (request && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read data captured during the wait cycle, valid at the grant
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 8'h00;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= acc.rdata;
        end
    end
endmodule

/* File: rtl/clock_select_irq_enable.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1 - enable bit 7 gates periodic interrupt
// R2 - enable bit 4 gates lock-change interrupt
// R3 - enable bit 1 gates self-clock interrupt
// R4 - enable register freely readable and writable
// R5 - pll select write of one ignored while unlocked
// R6 - pll select cleared on scm, stop, wait with pll halt set
// R7 - select picks oscillator or pll source
// R8 - software reads back pll select
// R9 - bit 6 keeps oscillator running in stop
// R10 - bit 5 reports oscillator configuration
// R11 - pll halt in wait powers pll down
// R12 - software reselects pll after wait
// R13 - periodic timer stops, resets in wait
// R14 - watchdog stops, resets in wait
// R15 - watchdog halt bit write-once normally
// R16 - periodic flag set on timeout, w1c
// R17 - lock flag set on lock change
// R18 - self-clock flag set on scm change
// R19 - control bits reset to zero
// R20 - irq is flag and enable
module clock_select_irq_enable
    import clock_select_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // avalon-mm register slave
    input  wire logic [4:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    // status from the rest of the clock unit
    input  wire logic       lock_status,
    input  wire logic       selfclk_mode_status,
    input  wire logic       periodic_timeout,
    input  wire logic       osc_config_strap,
    input  wire logic       special_mode,
    // low-power mode levels
    input  wire logic       stop_mode,
    input  wire logic       wait_mode,
    // clock source control
    output logic            pll_as_system_clock,
    output logic            osc_enable,
    output logic            pll_powered,
    // timer control
    output logic            periodic_halt,
    output logic            periodic_init,
    output logic            watchdog_halt,
    output logic            watchdog_init,
    // interrupt requests
    output logic            periodic_irq,
    output logic            lock_change_irq,
    output logic            selfclk_change_irq
);

    reg_access_if acc ();

    // control state
    logic [7:0] clock_irq_enable;
    logic       osc_run_in_stop;
    logic       osc_config_status;
    logic       pll_halt_in_wait;
    logic       periodic_halt_in_wait;
    logic       watchdog_halt_in_wait;
    logic       watchdog_bit_written;
    logic       strap_taken;

    // previous levels for entry and change detection
    logic       lock_prev;
    logic       selfclk_prev;
    logic       stop_prev;
    logic       wait_prev;

    // decoded events
    logic       wr_enable;
    logic       wr_select;
    logic       wr_flags;
    logic       stop_entry;
    logic       wait_entry;
    logic       selfclk_entry;
    logic       lock_changed;
    logic       selfclk_changed;
    logic       pll_auto_clear;
    logic       periodic_flag;
    logic       lock_change_flag;
    logic       selfclk_change_flag;
    logic       next_pll_as_system_clock;
    logic [7:0] next_rdata;

    // bus handshake
    avalon_reg_port u_port (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .acc             (acc)
    );

    // write strobes per register
    assign wr_enable = acc.access & acc.write & (acc.index == IDX_IRQ_ENABLE); // [R4]
    assign wr_select = acc.access & acc.write & (acc.index == IDX_CLK_SELECT);
    assign wr_flags  = acc.access & acc.write & (acc.index == IDX_FLAGS);

    // level history for edge detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_prev    <= 1'b0;
            selfclk_prev <= 1'b0;
            stop_prev    <= 1'b0;
            wait_prev    <= 1'b0;
        end else begin
            lock_prev    <= lock_status;
            selfclk_prev <= selfclk_mode_status;
            stop_prev    <= stop_mode;
            wait_prev    <= wait_mode;
        end
    end

    // mode entries and status changes
    assign stop_entry      = stop_mode & ~stop_prev;
    assign wait_entry      = wait_mode & ~wait_prev;
    assign selfclk_entry   = selfclk_mode_status & ~selfclk_prev;
    assign lock_changed    = lock_status ^ lock_prev;             // [R17]
    assign selfclk_changed = selfclk_mode_status ^ selfclk_prev;  // [R18]

    // sticky flags, cleared by writing one
    change_flag u_periodic_flag (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .set_evt   (periodic_timeout), // [R16]
        .clear_req (wr_flags & acc.wdata[BIT_PERIODIC_FLAG]),
        .flag      (periodic_flag)
    );

    change_flag u_lock_flag (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .set_evt   (lock_changed), // [R17]
        .clear_req (wr_flags & acc.wdata[BIT_LOCK_FLAG]),
        .flag      (lock_change_flag)
    );

    change_flag u_selfclk_flag (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .set_evt   (selfclk_changed), // [R18]
        .clear_req (wr_flags & acc.wdata[BIT_SELFCLK_FLAG]),
        .flag      (selfclk_change_flag)
    );

    // interrupt enable register, no write condition
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_irq_enable <= IRQ_ENABLE_RESET; // [R19]
        end else if (wr_enable) begin
            clock_irq_enable <= acc.wdata; // [R4]
        end
    end

    // automatic deselection of the pll clock
    assign pll_auto_clear = selfclk_entry | stop_entry
                          | (wait_entry & pll_halt_in_wait); // [R6] [R11]

    // pll select: hardware clear beats a software set
    always_comb begin
        next_pll_as_system_clock = pll_as_system_clock;
        if (pll_auto_clear) begin
            next_pll_as_system_clock = 1'b0; // [R6]
        end else if (wr_select) begin
            if (!acc.wdata[BIT_PLL_AS_SYSTEM_CLOCK]) begin
                next_pll_as_system_clock = 1'b0;
            end else if (lock_status) begin
                next_pll_as_system_clock = 1'b1; // [R5]
            end
        end
    end

    // source select output feeds the clock switch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_as_system_clock <= CTRL_BIT_RESET; // [R19]
        end else begin
            pll_as_system_clock <= next_pll_as_system_clock; // [R7]
        end
    end

    // oscillator behaviour in stop, writable anytime
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_run_in_stop <= CTRL_BIT_RESET; // [R19]
        end else if (wr_select) begin
            osc_run_in_stop <= acc.wdata[BIT_OSC_RUN_IN_STOP]; // [R9]
        end
    end

    // pll halt in wait, writable anytime
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_halt_in_wait <= CTRL_BIT_RESET; // [R19]
        end else if (wr_select) begin
            pll_halt_in_wait <= acc.wdata[BIT_PLL_HALT_WAIT]; // [R11]
        end
    end

    // periodic timer halt in wait, writable anytime
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            periodic_halt_in_wait <= CTRL_BIT_RESET; // [R19]
        end else if (wr_select) begin
            periodic_halt_in_wait <= acc.wdata[BIT_PERIODIC_HALT]; // [R13]
        end
    end

    // watchdog halt bit: once in normal modes, always in special
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_halt_in_wait <= CTRL_BIT_RESET; // [R19]
            watchdog_bit_written  <= 1'b0;
        end else if (wr_select) begin
            if (special_mode || !watchdog_bit_written) begin
                watchdog_halt_in_wait <= acc.wdata[BIT_WATCHDOG_HALT]; // [R15]
            end
            watchdog_bit_written <= 1'b1; // [R15]
        end
    end

    // oscillator configuration caught once after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_config_status <= 1'b0;
            strap_taken       <= 1'b0;
        end else if (!strap_taken) begin
            osc_config_status <= osc_config_strap; // [R10]
            strap_taken       <= 1'b1;
        end
    end

    // oscillator stays on outside stop or in pseudo stop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_enable <= 1'b1;
        end else begin
            osc_enable <= ~stop_mode | osc_run_in_stop; // [R9]
        end
    end

    // pll powered down only while waiting with halt set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_powered <= 1'b1;
        end else begin
            pll_powered <= ~(wait_mode & pll_halt_in_wait); // [R11]
        end
    end

    // periodic timer halt while waiting, init pulse on wait entry
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            periodic_halt <= 1'b0;
            periodic_init <= 1'b0;
        end else begin
            periodic_halt <= wait_mode & periodic_halt_in_wait;  // [R13]
            periodic_init <= wait_entry & periodic_halt_in_wait; // [R13]
        end
    end

    // watchdog halt while waiting, init pulse on wait entry
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_halt <= 1'b0;
            watchdog_init <= 1'b0;
        end else begin
            watchdog_halt <= wait_mode & watchdog_halt_in_wait;  // [R14]
            watchdog_init <= wait_entry & watchdog_halt_in_wait; // [R14]
        end
    end

    // periodic request follows flag and enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            periodic_irq <= 1'b0;
        end else begin
            periodic_irq <= periodic_flag
                          & clock_irq_enable[BIT_PERIODIC_IRQ_EN]; // [R1] [R20]
        end
    end

    // lock-change request follows flag and enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_change_irq <= 1'b0;
        end else begin
            lock_change_irq <= lock_change_flag
                             & clock_irq_enable[BIT_LOCK_IRQ_EN]; // [R2] [R20]
        end
    end

    // self-clock request follows flag and enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            selfclk_change_irq <= 1'b0;
        end else begin
            selfclk_change_irq <= selfclk_change_flag
                                & clock_irq_enable[BIT_SELFCLK_IRQ_EN]; // [R3] [R20]
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        next_rdata = RDATA_UNMAPPED;
        case (acc.index)
            IDX_IRQ_ENABLE: begin
                next_rdata = clock_irq_enable; // [R4]
            end
            IDX_CLK_SELECT: begin
                next_rdata[BIT_PLL_AS_SYSTEM_CLOCK]   = pll_as_system_clock; // [R8]
                next_rdata[BIT_OSC_RUN_IN_STOP] = osc_run_in_stop;
                next_rdata[BIT_OSC_CONFIG]      = osc_config_status; // [R10]
                next_rdata[BIT_PLL_HALT_WAIT]   = pll_halt_in_wait;
                next_rdata[BIT_PERIODIC_HALT]   = periodic_halt_in_wait;
                next_rdata[BIT_WATCHDOG_HALT]   = watchdog_halt_in_wait;
            end
            IDX_FLAGS: begin
                next_rdata[BIT_PERIODIC_FLAG]  = periodic_flag;
                next_rdata[BIT_LOCK_FLAG]      = lock_change_flag;
                next_rdata[BIT_LOCK_STATUS]    = lock_status;
                next_rdata[BIT_SELFCLK_FLAG]   = selfclk_change_flag;
                next_rdata[BIT_SELFCLK_STATUS] = selfclk_mode_status;
            end
            default: begin
                next_rdata = RDATA_UNMAPPED;
            end
        endcase
    end

    assign acc.rdata = next_rdata;

endmodule

/* File: test/clock_select_irq_enable_properties.sv */
`timescale 1ns/1ps
module clock_select_irq_enable_props
    import clock_select_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic [7:0] avs_readdata,
    input wire logic       avs_waitrequest,
    // status and modes
    input wire logic       lock_status,
    input wire logic       selfclk_mode_status,
    input wire logic       stop_mode,
    input wire logic       wait_mode,
    // clock and timer controls
    input wire logic       pll_as_system_clock,
    input wire logic       osc_enable,
    input wire logic       pll_powered,
    input wire logic       periodic_halt,
    input wire logic       periodic_init,
    input wire logic       watchdog_halt,
    input wire logic       watchdog_init
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // bus answers after exactly one wait cycle
    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("waitrequest not released after one cycle");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");
    // unused select bits read zero
    property p_sel_gaps;
        avs_read && !avs_waitrequest && avs_address[4:2] == IDX_CLK_SELECT
            |-> avs_readdata[4] == 1'b0 && avs_readdata[2] == 1'b0;
    endproperty
    a_sel_gaps: assert property (p_sel_gaps)
        else $error("unused select bits not zero");
    // pll only chosen while locked
    property p_sel_lock;
        $rose(pll_as_system_clock) |-> $past(lock_status);
    endproperty
    a_sel_lock: assert property (p_sel_lock)
        else $error("pll selected while unlocked");
    // automatic deselect on stop and self clock entry
    property p_clr_stop;
        $rose(stop_mode) |=> !pll_as_system_clock;
    endproperty
    a_clr_stop: assert property (p_clr_stop)
        else $error("pll select kept on stop entry");
    property p_clr_scm;
        $rose(selfclk_mode_status) |=> !pll_as_system_clock;
    endproperty
    a_clr_scm: assert property (p_clr_scm)
        else $error("pll select kept on self clock entry");
    // oscillator and pll power outside low-power modes
    property p_osc_run;
        !$past(stop_mode) |-> osc_enable;
    endproperty
    a_osc_run: assert property (p_osc_run)
        else $error("oscillator off outside stop");
    property p_pll_pwr;
        !$past(wait_mode) |-> pll_powered;
    endproperty
    a_pll_pwr: assert property (p_pll_pwr)
        else $error("pll powered down outside wait");
    // timer init only with halt after wait, init is a single pulse
    property p_rti_init;
        periodic_init |-> periodic_halt && $past(wait_mode) ##1 !periodic_init;
    endproperty
    a_rti_init: assert property (p_rti_init)
        else $error("periodic init pulse wrong");
    property p_cop_init;
        watchdog_init |-> watchdog_halt && $past(wait_mode) ##1 !watchdog_init;
    endproperty
    a_cop_init: assert property (p_cop_init)
        else $error("watchdog init pulse wrong");
endmodule

bind clock_select_irq_enable clock_select_irq_enable_props u_props (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lock_status(lock_status), .selfclk_mode_status(selfclk_mode_status),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .pll_as_system_clock(pll_as_system_clock),
    .osc_enable(osc_enable), .pll_powered(pll_powered), .periodic_halt(periodic_halt),
    .periodic_init(periodic_init), .watchdog_halt(watchdog_halt),
    .watchdog_init(watchdog_init)
);

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top;
    import clock_select_pkg::*;
    // stimulus and observed signals
    logic       clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [7:0] avs_writedata, avs_readdata, rd;
    logic       lock_status, selfclk_mode_status, periodic_timeout, osc_config_strap;
    logic       special_mode, stop_mode, wait_mode, pll_as_system_clock, osc_enable, pll_powered;
    logic       periodic_halt, periodic_init, watchdog_halt, watchdog_init;
    logic       periodic_irq, lock_change_irq, selfclk_change_irq;
    int         num_errors, check_count, cycles;
    wire  [2:0] irqs = {periodic_irq, lock_change_irq, selfclk_change_irq};
    localparam logic [7:0] PATS[3] = '{8'hFF, 8'h6D, 8'h00};
    localparam logic [7:0] ENS[3]  = '{8'h80, 8'h10, 8'h02};

    // design under test
    clock_select_irq_enable DUT (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lock_status(lock_status),
        .selfclk_mode_status(selfclk_mode_status), .periodic_timeout(periodic_timeout),
        .osc_config_strap(osc_config_strap), .special_mode(special_mode),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .pll_as_system_clock(pll_as_system_clock),
        .osc_enable(osc_enable), .pll_powered(pll_powered), .periodic_halt(periodic_halt),
        .periodic_init(periodic_init), .watchdog_halt(watchdog_halt),
        .watchdog_init(watchdog_init), .periodic_irq(periodic_irq),
        .lock_change_irq(lock_change_irq), .selfclk_change_irq(selfclk_change_irq)
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    // counts and verdict
    task print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one bus access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [2:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK(n, 2)
        @(posedge clk);
    endtask

    task wr(input logic [2:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task rdchk(input logic [2:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        `CHK(rd, exp)
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // reset values and free access to the enable register
    task t_reset;
        `CHK({osc_enable, pll_powered, pll_as_system_clock, irqs}, 6'h30)
        rdchk(IDX_IRQ_ENABLE, IRQ_ENABLE_RESET);
        rdchk(IDX_CLK_SELECT, 8'h20);
        rdchk(3'h7, RDATA_UNMAPPED);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_IRQ_ENABLE, PATS[i]);
            rdchk(IDX_IRQ_ENABLE, PATS[i]);
        end
        $display("test reset done");
    endtask

    // flags, per-source gating and clearing
    task t_irq;
        lock_status <= 1'b1;
        selfclk_mode_status <= 1'b1;
        periodic_timeout <= 1'b1;
        @(posedge clk);
        periodic_timeout <= 1'b0;
        selfclk_mode_status <= 1'b0;
        cyc(3);
        `CHK(irqs, 3'b000)
        rdchk(IDX_FLAGS, 8'h9A);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_IRQ_ENABLE, ENS[i]);
            cyc(1);
            `CHK(irqs, {ENS[i][7], ENS[i][4], ENS[i][1]})
        end
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h92);
        cyc(1);
        `CHK(irqs, 3'b111)
        wr(IDX_FLAGS, 8'h92);
        cyc(1);
        `CHK(irqs, 3'b000)
        $display("test irq done");
    endtask

    // timer halt in wait and write-once watchdog bit
    task t_timers;
        wr(IDX_CLK_SELECT, 8'h03);
        wait_mode <= 1'b1;
        cyc(2);
        `CHK({periodic_halt, periodic_init, watchdog_halt, watchdog_init}, 4'hF)
        cyc(1);
        `CHK({periodic_halt, periodic_init, watchdog_halt, watchdog_init}, 4'hA)
        wait_mode <= 1'b0;
        cyc(2);
        wr(IDX_CLK_SELECT, 8'h00);
        rdchk(IDX_CLK_SELECT, 8'h21);
        special_mode <= 1'b1;
        wr(IDX_CLK_SELECT, 8'h00);
        rdchk(IDX_CLK_SELECT, 8'h20);
        $display("test timers done");
    endtask

    // pll select guarding and automatic deselect
    task t_pll;
        lock_status <= 1'b0;
        cyc(3);
        `CHK(lock_change_irq, 1'b1)
        wr(IDX_CLK_SELECT, 8'h80);
        rdchk(IDX_CLK_SELECT, 8'h20);
        lock_status <= 1'b1;
        wr(IDX_CLK_SELECT, 8'h80);
        rdchk(IDX_CLK_SELECT, 8'hA0);
        `CHK(pll_as_system_clock, 1'b1)
        stop_mode <= 1'b1;
        cyc(3);
        `CHK({pll_as_system_clock, osc_enable}, 2'b00)
        stop_mode <= 1'b0;
        wr(IDX_CLK_SELECT, 8'hC0);
        stop_mode <= 1'b1;
        cyc(3);
        `CHK({pll_as_system_clock, osc_enable}, 2'b01)
        stop_mode <= 1'b0;
        wr(IDX_CLK_SELECT, 8'h88);
        wait_mode <= 1'b1;
        cyc(3);
        `CHK({pll_as_system_clock, pll_powered, periodic_halt}, 3'b000)
        wait_mode <= 1'b0;
        cyc(3);
        `CHK({pll_as_system_clock, pll_powered}, 2'b01)
        wr(IDX_CLK_SELECT, 8'h80);
        wait_mode <= 1'b1;
        cyc(3);
        `CHK({pll_as_system_clock, pll_powered}, 2'b11)
        wait_mode <= 1'b0;
        selfclk_mode_status <= 1'b1;
        cyc(3);
        `CHK(pll_as_system_clock, 1'b0)
        $display("test pll done");
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {lock_status, selfclk_mode_status, periodic_timeout, special_mode} = '0;
        {stop_mode, wait_mode} = '0;
        osc_config_strap = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_irq();
        t_timers();
        t_pll();
        print_verdict();
    end
endmodule
